/* File: bench/txf_host_model.sv */
// Purpose: Host writer model driving the transmit FIFO pins
// Assumes: Pin clocks free-running, unrelated to the system clock
// Notes: Pins change on host clock falling edges, away from capture
module txf_host_model (
	input wire logic wr_go,
	input wire logic [8:0] wr_num,
	input wire logic flag_polarity_sel,
	output logic tx_host_clk,
	output logic ref_clk_a,
	output logic tx_write_enable,
	output logic [txf_pkg::CHAR_W-1:0] tx_data,
	output logic wr_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic seen, last, act;
	logic [8:0] pend;
	logic [txf_pkg::CHAR_W-1:0] cnt;
	initial begin
		tx_host_clk = 1'h0;
		forever #100 tx_host_clk = ~tx_host_clk;
	end
	initial begin
		ref_clk_a = 1'h0;
		#37;
		forever #120 ref_clk_a = ~ref_clk_a;
	end
	initial begin
		seen = 1'h0;
		last = 1'h0;
		pend = 9'h0;
		cnt = '0;
		tx_write_enable = 1'h1;
		tx_data = '0;
	end
	assign wr_busy = (wr_go != seen) || (pend != 9'h0) || last;
	always @(negedge tx_host_clk) begin
		if (wr_go != seen) begin
			pend = wr_num;
			seen = wr_go;
		end
		act = (pend != 9'h0);
		if (act) pend = pend - 9'h1;
		tx_write_enable <= act ? flag_polarity_sel : !flag_polarity_sel;
		// High polarity captures one edge later, so data must still be valid then
		if (flag_polarity_sel ? last : act) begin
			cnt = cnt + 1'h1;
			tx_data <= cnt;
		end else tx_data <= ~tx_data;
		last = act;
	end
endmodule : txf_host_model

/* File: bench/txf_props.sv */
// Purpose: Port-level checks for the transmit FIFO control block
// Assumes: Pins stay steady long enough to pass the input synchronisers
// Notes: Counters stand in for long waits on pin clock edges
module txf_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic tx_fifo_reset_n,
	input wire logic tx_halt_n,
	input wire logic tx_write_enable,
	input wire logic chip_enable_n,
	input wire logic fifo_bypass_n,
	input wire logic flag_polarity_sel,
	input wire logic chip_reset_n,
	input wire logic tx_full_flag,
	input wire logic tx_half_flag,
	input wire logic tx_half_oe_n,
	input wire logic tx_empty_flag,
	input wire logic [txf_pkg::CHAR_W-1:0] tx_char,
	input wire logic tx_char_strobe,
	input wire logic tx_sending_sync
);
	logic [7:0] rst_cnt;
	logic [6:0] halt_cnt;
	logic rst_qual;
	assign rst_qual = !tx_fifo_reset_n && fifo_bypass_n && !chip_enable_n && chip_reset_n
		&& (tx_write_enable == !flag_polarity_sel);
	// Saturating counts: long enough for seven host edges plus synchroniser delay
	always_ff @(posedge aclk) begin
		if (!aresetn || !rst_qual) rst_cnt <= 8'h0;
		else if (rst_cnt != 8'hC8) rst_cnt <= rst_cnt + 8'h1;
		if (!aresetn || tx_halt_n) halt_cnt <= 7'h0;
		else if (halt_cnt != 7'h64) halt_cnt <= halt_cnt + 7'h1;
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	aw_pair_a: assert property (awready |-> wready)
		else $error("write address and data ready differ");
	wr_resp_a: assert property (awvalid && awready |=> bvalid)
		else $error("write response late");
	rd_resp_a: assert property (arready |=> rvalid)
		else $error("read response late");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data not held");
	rst_force_a: assert property (rst_cnt == 8'hC8 |-> tx_full_flag == flag_polarity_sel
		&& tx_half_flag == flag_polarity_sel && tx_empty_flag != flag_polarity_sel)
		else $error("flags not forced during fifo reset");
	byp_half_a: assert property ((!fifo_bypass_n && chip_reset_n && $stable(flag_polarity_sel))[*8]
		|-> tx_half_flag != flag_polarity_sel)
		else $error("half flag asserted in bypass");
	half_float_a: assert property ($stable(chip_reset_n)[*8] |-> tx_half_oe_n == !chip_reset_n)
		else $error("half flag enable wrong");
	halt_sync_a: assert property (halt_cnt == 7'h64 && tx_char_strobe
		|-> tx_sending_sync && tx_char == 12'h0)
		else $error("data sent while halted");
endmodule : txf_props

bind txf_top txf_props txf_props_inst (.aclk, .aresetn, .awvalid, .awready, .wready, .bvalid,
	.arready, .rdata, .rvalid, .rready, .tx_fifo_reset_n, .tx_halt_n, .tx_write_enable,
	.chip_enable_n, .fifo_bypass_n, .flag_polarity_sel, .chip_reset_n, .tx_full_flag,
	.tx_half_flag, .tx_half_oe_n, .tx_empty_flag, .tx_char, .tx_char_strobe, .tx_sending_sync);

/* File: bench/txf_top_test.sv */
// Purpose: Self-checking bench for the transmit FIFO control block
// Assumes: Host clock 200 ns, reference clock 240 ns
// Notes: Waits after pin changes allow for the input synchronisers
module txf_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
	logic arready, rvalid, tx_host_clk, ref_clk_a, tx_fifo_reset_n, tx_halt_n, tx_write_enable;
	logic chip_enable_n, fifo_bypass_n, flag_polarity_sel, freq_range_sel, speed_sel;
	logic chip_reset_n, tx_full_flag, tx_full_oe_n, tx_half_flag, tx_half_oe_n, tx_empty_flag;
	logic tx_empty_oe_n, tx_char_strobe, tx_sending_sync, wr_go, wr_busy;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rd_data;
	logic [1:0] bresp, rresp, rs;
	logic [8:0] wr_num;
	logic [txf_pkg::CHAR_W-1:0] tx_data, tx_char;
	int error_cnt, num_checks;
	txf_top txf_top_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .tx_host_clk, .ref_clk_a, .tx_fifo_reset_n, .tx_halt_n, .tx_write_enable,
		.chip_enable_n, .fifo_bypass_n, .flag_polarity_sel, .freq_range_sel, .speed_sel,
		.chip_reset_n, .tx_data, .tx_full_flag, .tx_full_oe_n, .tx_half_flag, .tx_half_oe_n,
		.tx_empty_flag, .tx_empty_oe_n, .tx_char, .tx_char_strobe, .tx_sending_sync);
	txf_host_model txf_host_model_inst (.wr_go, .wr_num, .flag_polarity_sel, .tx_host_clk,
		.ref_clk_a, .tx_write_enable, .tx_data, .wr_busy);
	initial begin
		aclk = 1'h0;
		forever #12.5 aclk = ~aclk;
	end
	task conclude();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : conclude
	initial begin
		#600us;
		error_cnt++;
		conclude();
	end
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task waitc(input int n);
		repeat (n) @(posedge aclk);
	endtask : waitc
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do @(negedge aclk); while (awready !== 1'h1);
		@(posedge aclk);
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		do @(negedge aclk); while (bvalid !== 1'h1);
		rs = bresp;
		@(posedge aclk);
		bready <= 1'h0;
	endtask : wr
	// Ready raised late so the slave must hold its answer
	task rd(input logic [3:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		do @(negedge aclk); while (arready !== 1'h1);
		@(posedge aclk);
		arvalid <= 1'h0;
		do @(negedge aclk); while (rvalid !== 1'h1);
		@(posedge aclk);
		rready <= 1'h1;
		@(negedge aclk);
		rd_data = rdata;
		rs = rresp;
		@(posedge aclk);
		rready <= 1'h0;
	endtask : rd
	task put(input logic [8:0] n);
		@(posedge aclk);
		wr_num <= n;
		wr_go <= ~wr_go;
		do @(negedge aclk); while (wr_busy);
		waitc(20);
	endtask : put
	task t_regs();
		rd(txf_pkg::REG_CTRL);
		chk("ctrl", 32'h0, rd_data);
		rd(4'hC);
		chk("unmapped resp", txf_pkg::RESP_SLVERR, rs);
		wr(txf_pkg::REG_LEVEL, 32'h5);
		chk("ro write resp", txf_pkg::RESP_OKAY, rs);
		rd(txf_pkg::REG_LEVEL);
		chk("level", 32'h0, rd_data);
		wr(txf_pkg::REG_CTRL, 32'h2);
		waitc(100);
		rd(txf_pkg::REG_CTRL);
		chk("ctrl", 32'h2, rd_data);
		rd(txf_pkg::REG_STATUS);
		chk("reset busy", 32'h1, rd_data[3]);
		wr(txf_pkg::REG_CTRL, 32'h0);
		waitc(20);
		rd(txf_pkg::REG_STATUS);
		chk("reset busy", 32'h0, rd_data[3]);
	endtask : t_regs
	task t_fill();
		put(9'h7F);
		chk("half", !flag_polarity_sel, tx_half_flag);
		put(9'h1);
		chk("half", flag_polarity_sel, tx_half_flag);
		rd(txf_pkg::REG_LEVEL);
		chk("level", 32'h80, rd_data);
		put(9'h7B);
		chk("full", !flag_polarity_sel, tx_full_flag);
		put(9'h1);
		chk("full", flag_polarity_sel, tx_full_flag);
	endtask : t_fill
	task t_short();
		tx_fifo_reset_n <= 1'h0;
		waitc(40);
		tx_fifo_reset_n <= 1'h1;
		waitc(20);
		rd(txf_pkg::REG_LEVEL);
		chk("level", 32'hFC, rd_data);
	endtask : t_short
	task t_halt();
		int i;
		logic [11:0] ch;
		ch = 12'hFFF;
		@(posedge aclk);
		tx_halt_n <= 1'h1;
		for (i = 0; i < 400 && ch === 12'hFFF; i++) begin
			@(negedge aclk);
			if (tx_char_strobe === 1'h1 && tx_sending_sync === 1'h0) ch = tx_char;
		end
		@(posedge aclk);
		tx_halt_n <= 1'h0;
		chk("first char", 32'h1, ch);
	endtask : t_halt
	task t_reset();
		tx_fifo_reset_n <= 1'h0;
		waitc(250);
		chk("full", flag_polarity_sel, tx_full_flag);
		chk("half", flag_polarity_sel, tx_half_flag);
		chk("empty", !flag_polarity_sel, tx_empty_flag);
		rd(txf_pkg::REG_STATUS);
		chk("reset busy", 32'h1, rd_data[3]);
		rd(txf_pkg::REG_LEVEL);
		chk("level", 32'h0, rd_data);
		tx_fifo_reset_n <= 1'h1;
		waitc(40);
		chk("full", !flag_polarity_sel, tx_full_flag);
		chk("empty", flag_polarity_sel, tx_empty_flag);
		chk("half", !flag_polarity_sel, tx_half_flag);
	endtask : t_reset
	task t_bypass();
		int n;
		logic f;
		fifo_bypass_n <= 1'h0;
		tx_fifo_reset_n <= 1'h0;
		waitc(200);
		rd(txf_pkg::REG_STATUS);
		chk("reset busy", 32'h0, rd_data[3]);
		chk("half", !flag_polarity_sel, tx_half_flag);
		chk("full", !flag_polarity_sel, tx_full_flag);
		freq_range_sel <= 1'h1;
		waitc(20);
		n = 0;
		f = tx_full_flag;
		repeat (96) begin
			@(negedge aclk);
			if (tx_full_flag !== f) n++;
			f = tx_full_flag;
		end
		// Ten reference periods, one toggle per reference edge
		chk("full toggles", 32'h1, n >= 9 && n <= 11);
		@(posedge aclk);
		freq_range_sel <= 1'h0;
		tx_fifo_reset_n <= 1'h1;
		fifo_bypass_n <= 1'h1;
		waitc(20);
	endtask : t_bypass
	task t_pol();
		chip_enable_n <= 1'h1;
		// A host edge must see CE high before the enable polarity flips
		waitc(20);
		chk("full oe", 32'h1, tx_full_oe_n);
		chk("empty oe", 32'h1, tx_empty_oe_n);
		flag_polarity_sel <= 1'h1;
		waitc(20);
		chip_enable_n <= 1'h0;
		waitc(20);
		put(9'h3);
		rd(txf_pkg::REG_LEVEL);
		chk("level", 32'h3, rd_data);
		chk("empty", 32'h0, tx_empty_flag);
		chk("full", 32'h0, tx_full_flag);
		chk("full oe", 32'h0, tx_full_oe_n);
	endtask : t_pol
	task t_chip();
		chip_reset_n <= 1'h0;
		waitc(12);
		chk("half oe", 32'h1, tx_half_oe_n);
		chip_reset_n <= 1'h1;
		waitc(12);
		chk("half oe", 32'h0, tx_half_oe_n);
	endtask : t_chip
	initial begin
		aresetn = 1'h0;
		{awvalid, wvalid, bready, arvalid, rready, wr_go} = 6'h0;
		awaddr = 4'h0;
		araddr = 4'h0;
		wdata = 32'h0;
		wstrb = 4'hF;
		wr_num = 9'h0;
		{tx_fifo_reset_n, tx_halt_n, chip_enable_n, flag_polarity_sel, freq_range_sel} = 5'h10;
		{fifo_bypass_n, speed_sel, chip_reset_n} = 3'h7;
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		waitc(8);
		t_regs();
		t_fill();
		t_short();
		t_halt();
		t_reset();
		t_bypass();
		t_pol();
		t_chip();
		conclude();
	end
endmodule : txf_top_test

/* File: pkg/txf_pkg.sv */
// Purpose: Shared constants and types for the transmit FIFO control block
// Assumes: One system clock samples every pin, including both pin clocks
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite bus
package txf_pkg;
	localparam int CHAR_W = 12;
	localparam int FIFO_DEPTH = 256;
	localparam int FULL_MARGIN = 4;
	localparam int HALF_LEVEL = 128;
	localparam logic [2:0] RST_SAMPLES = 3'h7;
	localparam logic [2:0] RST_CNT_RESET = 3'h0;

	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_LEVEL = 4'h8;
	localparam int CTRL_HALT_BIT = 0;
	localparam int CTRL_RST_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		TXF_RS_IDLE = 2'h0,
		TXF_RS_HOST = 2'h1,
		TXF_RS_BOTH = 2'h3
	} txf_rst_state_t;

	typedef struct packed {
		logic host_clk;
		logic ref_clk;
		logic fifo_reset_n;
		logic halt_n;
		logic write_enable;
		logic chip_enable_n;
		logic fifo_bypass_n;
		logic flag_polarity_sel;
		logic freq_range_sel;
		logic speed_sel;
		logic chip_reset_n;
		logic [CHAR_W-1:0] data;
	} txf_pins_t;
endpackage : txf_pkg

/* File: verilog/txf_sync3.sv */
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk
// Notes: Output moves only when stages two and three agree
module txf_sync3 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic aresetn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_dout;

	always_comb begin
		next_dout = dout;
		for (int i = 0; i < W; i++) begin
			if (s2[i] == s3[i]) begin
				next_dout[i] = s3[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!aresetn) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			dout <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			dout <= next_dout;
		end
	end
endmodule : txf_sync3

/* File: verilog/txf_top.sv */
// Purpose: Transmit FIFO reset, halt and status flag logic with AXI4-Lite access
// Assumes: aclk oversamples both pin clocks; pin clocks far slower than aclk
// Notes: Host and serial sides are edge-qualified processes on aclk
// Functional notes
// - Reset input low for seven host samples, FIFO on, CE low, no write: reset.
// - Reset start asserts full and zeroes host write pointer.
// - Reset crosses to serial side, clearing its read pointer.
// - Full stays asserted until both sides finished reset.
// - While reset input stays low, FIFO held in reset, full asserted.
// - In bypass mode the FIFO reset input is ignored.
// - Halt low sends idle sync characters; halt high resumes data.
// - Host writes still accepted while transmission is halted.
// - Full asserted when four or fewer characters remain writable.
// - Full forced asserted for the whole FIFO reset.
// - Bypass: full follows transmitter busy, updated on reference edges.
// - Bypass with double-rate reference: full toggles at character rate.
// - Full polarity follows the polarity select input.
// - Half flag asserted when FIFO holds 128 characters.
// - Half flag forced asserted during FIFO reset.
// - Bypass: half flag permanently deasserted.
// - Half output floats only while full-chip reset is low.
// - Empty deasserted during FIFO reset until it completes.
// - Write enable polarity follows select; high polarity captures next cycle.
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
module txf_top #(
	parameter int DEPTH = txf_pkg::FIFO_DEPTH
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [txf_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [txf_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic tx_host_clk,
	input wire logic ref_clk_a,
	input wire logic tx_fifo_reset_n,
	input wire logic tx_halt_n,
	input wire logic tx_write_enable,
	input wire logic chip_enable_n,
	input wire logic fifo_bypass_n,
	input wire logic flag_polarity_sel,
	input wire logic freq_range_sel,
	input wire logic speed_sel,
	input wire logic chip_reset_n,
	input wire logic [txf_pkg::CHAR_W-1:0] tx_data,
	output logic tx_full_flag,
	output logic tx_full_oe_n,
	output logic tx_half_flag,
	output logic tx_half_oe_n,
	output logic tx_empty_flag,
	output logic tx_empty_oe_n,
	output logic [txf_pkg::CHAR_W-1:0] tx_char,
	output logic tx_char_strobe,
	output logic tx_sending_sync
);
	localparam int PW = $clog2(DEPTH) + 1;
	localparam logic [PW-1:0] FULL_LVL = PW'(DEPTH - txf_pkg::FULL_MARGIN);
	localparam logic [PW-1:0] HALF_LVL = PW'(txf_pkg::HALF_LEVEL);

	function automatic logic we_active(input logic we, input logic pol);
		we_active = pol ? we : ~we;
	endfunction : we_active

	function automatic logic flag_drive(input logic act, input logic pol);
		flag_drive = pol ? act : ~act;
	endfunction : flag_drive

	txf_pkg::txf_pins_t raw;
	txf_pkg::txf_pins_t pins;
	logic [$bits(txf_pkg::txf_pins_t)-1:0] pins_bits;

	assign raw = '{host_clk: tx_host_clk, ref_clk: ref_clk_a, fifo_reset_n: tx_fifo_reset_n,
		halt_n: tx_halt_n, write_enable: tx_write_enable, chip_enable_n: chip_enable_n,
		fifo_bypass_n: fifo_bypass_n, flag_polarity_sel: flag_polarity_sel,
		freq_range_sel: freq_range_sel, speed_sel: speed_sel, chip_reset_n: chip_reset_n,
		data: tx_data};

	txf_sync3 #(.W($bits(txf_pkg::txf_pins_t))) txf_sync3_inst (
		.clk(aclk),
		.aresetn(aresetn),
		.din(raw),
		.dout(pins_bits)
	);
	assign pins = txf_pkg::txf_pins_t'(pins_bits);

	logic [txf_pkg::CHAR_W-1:0] mem [DEPTH];
	logic [PW-1:0] wptr;
	logic [PW-1:0] rptr;
	logic [PW-1:0] level;
	logic [1:0] ctrl;

	logic host_q;
	logic ref_q;
	logic ce_prev_low;
	logic arm;
	logic halt_q;
	logic [2:0] rst_cnt;
	txf_pkg::txf_rst_state_t rs_state;
	logic rd_rst_req;
	logic rd_rst_done;
	logic char_phase;
	logic byp_pending;
	logic [txf_pkg::CHAR_W-1:0] byp_hold;
	logic byp_full_act;

	logic host_edge;
	logic ref_edge;
	logic fifo_en;
	logic pol;
	logic div2;
	logic sample_edge;
	logic we_act;
	logic sel;
	logic wr_go;
	logic rst_in;
	logic rst_cond;
	logic resetting;
	logic halted;
	logic chip_rst;
	logic full_act;
	logic half_act;
	logic empty_act;

	assign host_edge = pins.host_clk & ~host_q;
	assign ref_edge = pins.ref_clk & ~ref_q;
	assign fifo_en = pins.fifo_bypass_n;
	assign pol = pins.flag_polarity_sel;
	assign div2 = pins.freq_range_sel | ~pins.speed_sel;
	// Bypass path is clocked by the reference, FIFO path by the host clock
	assign sample_edge = fifo_en ? host_edge : ref_edge;
	assign we_act = we_active(pins.write_enable, pol);
	assign sel = we_act & ce_prev_low;
	assign chip_rst = ~pins.chip_reset_n;
	assign level = wptr - rptr;
	assign resetting = (rs_state != txf_pkg::TXF_RS_IDLE);
	assign halted = ~halt_q | ctrl[txf_pkg::CTRL_HALT_BIT];
	assign rst_in = ~pins.fifo_reset_n | ctrl[txf_pkg::CTRL_RST_BIT];
	assign rst_cond = fifo_en & ~pins.chip_enable_n & ~we_act & rst_in;
	// capture timing and writes unaffected by halt
	assign wr_go = sample_edge & (pol ? arm : sel) & ~chip_rst & (fifo_en ?
		(~resetting & (level != PW'(DEPTH))) : (~byp_full_act & ~byp_pending));

	// Host side next state
	logic next_ce_prev_low;
	logic next_arm;
	logic next_halt_q;
	logic [2:0] next_rst_cnt;
	txf_pkg::txf_rst_state_t next_rs_state;
	logic [PW-1:0] next_wptr;
	logic next_rd_rst_req;

	always_comb begin
		next_ce_prev_low = ce_prev_low;
		next_arm = arm;
		next_halt_q = halt_q;
		next_rst_cnt = rst_cnt;
		next_rs_state = rs_state;
		next_wptr = wptr;
		next_rd_rst_req = rd_rst_req;
		if (sample_edge) begin
			next_ce_prev_low = ~pins.chip_enable_n;
			next_arm = sel;
		end
		if (host_edge) begin
			next_halt_q = pins.halt_n;
			if (rst_cond) begin
				next_rst_cnt = (rst_cnt == txf_pkg::RST_SAMPLES) ? rst_cnt : rst_cnt + 3'h1;
			end else begin
				next_rst_cnt = txf_pkg::RST_CNT_RESET;
			end
		end
		if (wr_go && fifo_en) begin
			next_wptr = wptr + PW'(1);
		end
		unique case (rs_state)
			txf_pkg::TXF_RS_IDLE: begin
				if (host_edge && rst_cond && rst_cnt == txf_pkg::RST_SAMPLES - 3'h1) begin
					next_rs_state = txf_pkg::TXF_RS_HOST;
					next_wptr = '0;
					next_rd_rst_req = 1'b1;
				end
			end
			txf_pkg::TXF_RS_HOST: begin
				next_wptr = '0;
				if (rd_rst_done) begin
					next_rs_state = txf_pkg::TXF_RS_BOTH;
				end
			end
			txf_pkg::TXF_RS_BOTH: begin
				next_wptr = '0;
				if (host_edge && !rst_in) begin
					next_rs_state = txf_pkg::TXF_RS_IDLE;
					next_rd_rst_req = 1'b0;
				end
			end
			default: begin
				next_rs_state = txf_pkg::TXF_RS_IDLE;
			end
		endcase
		if (!fifo_en || chip_rst) begin
			next_rs_state = txf_pkg::TXF_RS_IDLE;
			next_rd_rst_req = 1'b0;
			next_rst_cnt = txf_pkg::RST_CNT_RESET;
		end
		if (chip_rst) begin
			next_wptr = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			host_q <= 1'b0;
			ref_q <= 1'b0;
			ce_prev_low <= 1'b0;
			arm <= 1'b0;
			halt_q <= 1'b1;
			rst_cnt <= txf_pkg::RST_CNT_RESET;
			rs_state <= txf_pkg::TXF_RS_IDLE;
			wptr <= '0;
			rd_rst_req <= 1'b0;
		end else begin
			host_q <= pins.host_clk;
			ref_q <= pins.ref_clk;
			ce_prev_low <= next_ce_prev_low;
			arm <= next_arm;
			halt_q <= next_halt_q;
			rst_cnt <= next_rst_cnt;
			rs_state <= next_rs_state;
			wptr <= next_wptr;
			rd_rst_req <= next_rd_rst_req;
		end
	end

	// Memory has no reset; pointers define its contents
	always_ff @(posedge aclk) begin
		if (wr_go && fifo_en) begin
			mem[wptr[PW-2:0]] <= pins.data;
		end
	end

	// Serial side next state
	logic [PW-1:0] next_rptr;
	logic next_rd_rst_done;
	logic next_char_phase;
	logic next_byp_pending;
	logic [txf_pkg::CHAR_W-1:0] next_byp_hold;
	logic next_byp_full_act;
	logic [txf_pkg::CHAR_W-1:0] next_tx_char;
	logic next_tx_char_strobe;
	logic next_tx_sending_sync;
	logic slot;
	logic no_data;

	always_comb begin
		next_rptr = rptr;
		next_rd_rst_done = rd_rst_done;
		next_char_phase = char_phase;
		next_byp_pending = byp_pending;
		next_byp_hold = byp_hold;
		next_byp_full_act = byp_full_act;
		next_tx_char = tx_char;
		next_tx_char_strobe = 1'b0;
		next_tx_sending_sync = tx_sending_sync;
		slot = ~div2 | char_phase;
		no_data = fifo_en ? (level == '0 || rd_rst_req) : ~byp_pending;
		if (ref_edge) begin
			next_char_phase = div2 & ~char_phase;
			next_rd_rst_done = rd_rst_req;
			if (rd_rst_req) begin
				next_rptr = '0;
			end
			if (slot) begin
				next_tx_char_strobe = 1'b1;
				if (halted || no_data) begin
					next_tx_sending_sync = 1'b1;
					next_tx_char = '0;
				end else begin
					next_tx_sending_sync = 1'b0;
					if (fifo_en) begin
						next_tx_char = mem[rptr[PW-2:0]];
						next_rptr = rptr + PW'(1);
					end else begin
						next_tx_char = byp_hold;
						next_byp_pending = 1'b0;
					end
				end
			end
		end
		if (wr_go && !fifo_en) begin
			next_byp_hold = pins.data;
			next_byp_pending = 1'b1;
		end
		if (ref_edge) begin
			// toggle at character rate, busy otherwise
			next_byp_full_act = div2 ? ~next_char_phase : next_byp_pending;
		end
		if (chip_rst) begin
			next_rptr = '0;
			next_rd_rst_done = 1'b0;
			next_byp_pending = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rptr <= '0;
			rd_rst_done <= 1'b0;
			char_phase <= 1'b0;
			byp_pending <= 1'b0;
			byp_hold <= '0;
			byp_full_act <= 1'b0;
			tx_char <= '0;
			tx_char_strobe <= 1'b0;
			tx_sending_sync <= 1'b1;
		end else begin
			rptr <= next_rptr;
			rd_rst_done <= next_rd_rst_done;
			char_phase <= next_char_phase;
			byp_pending <= next_byp_pending;
			byp_hold <= next_byp_hold;
			byp_full_act <= next_byp_full_act;
			tx_char <= next_tx_char;
			tx_char_strobe <= next_tx_char_strobe;
			tx_sending_sync <= next_tx_sending_sync;
		end
	end

	// Flags: full, half, empty
	always_comb begin
		full_act = fifo_en ? (resetting | (level >= FULL_LVL)) : byp_full_act;
		half_act = fifo_en & (resetting | (level >= HALF_LVL));
		empty_act = fifo_en ? (~resetting & (level == '0)) : ~byp_full_act;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_full_flag <= 1'b0;
			tx_half_flag <= 1'b0;
			tx_empty_flag <= 1'b0;
			tx_full_oe_n <= 1'b1;
			tx_half_oe_n <= 1'b1;
			tx_empty_oe_n <= 1'b1;
		end else begin
			tx_full_flag <= flag_drive(full_act, pol);
			tx_half_flag <= flag_drive(half_act, pol);
			tx_empty_flag <= flag_drive(empty_act, pol);
			tx_full_oe_n <= pins.chip_enable_n;
			tx_empty_oe_n <= pins.chip_enable_n;
			tx_half_oe_n <= chip_rst;
		end
	end

	// Register bus; a write waits for both address and data
	logic next_awready;
	logic next_bvalid;
	logic [1:0] next_bresp;
	logic [1:0] next_ctrl;
	logic next_arready;
	logic next_rvalid;
	logic [1:0] next_rresp;
	logic [31:0] next_rdata;

	always_comb begin
		next_awready = 1'b0;
		next_bvalid = bvalid & ~bready;
		next_bresp = bresp;
		next_ctrl = ctrl;
		next_arready = 1'b0;
		next_rvalid = rvalid & ~rready;
		next_rresp = rresp;
		next_rdata = rdata;
		if (!awready && !bvalid && awvalid && wvalid) begin
			next_awready = 1'b1;
		end
		if (awready) begin
			next_bvalid = 1'b1;
			next_bresp = txf_pkg::RESP_OKAY;
			if (awaddr == txf_pkg::REG_CTRL) begin
				if (wstrb[0]) begin
					next_ctrl = wdata[1:0];
				end
			end else if (awaddr != txf_pkg::REG_STATUS && awaddr != txf_pkg::REG_LEVEL) begin
				next_bresp = txf_pkg::RESP_SLVERR;
			end
		end
		if (!arready && !rvalid && arvalid) begin
			next_arready = 1'b1;
		end
		if (arready) begin
			next_rvalid = 1'b1;
			next_rresp = txf_pkg::RESP_OKAY;
			unique case (araddr)
				txf_pkg::REG_CTRL: next_rdata = {30'h0, ctrl};
				txf_pkg::REG_STATUS: next_rdata = {25'h0, tx_sending_sync, ~fifo_en, halted,
					resetting, empty_act, half_act, full_act};
				txf_pkg::REG_LEVEL: next_rdata = {{(32 - PW){1'b0}}, level};
				default: begin
					next_rdata = 32'h0;
					next_rresp = txf_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= txf_pkg::RESP_OKAY;
			ctrl <= txf_pkg::CTRL_RESET;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rresp <= txf_pkg::RESP_OKAY;
			rdata <= 32'h0;
		end else begin
			awready <= next_awready;
			wready <= next_awready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			ctrl <= next_ctrl;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
		end
	end
endmodule : txf_top
